// >>> design/rtc_cmd_ctrl.sv
`timescale 1ns/1ns
module rtc_cmd_ctrl
   import rtc_pkg::*;
#(
   parameter int         SLOW_CAL_CYCLES = SLOW_CAL_CYC,
   parameter int         VCO_CAL_CYCLES  = VCO_CAL_CYC,
   parameter int         BUF_DEPTH       = 2,
   parameter logic [7:0] ID_CODE         = 8'h5A // Arbitrary value
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       linkSelect_n,
   input  wire logic       linkClk,
   input  wire logic       linkDataIn,
   output logic            linkDataOut,
   output logic            linkDataOe,
   output logic [1:0]      bankSel,
   input  wire logic       dirModeEn,
   input  wire logic [2:0] operatingMode,
   input  wire logic       autoTxRxEnable,
   input  wire logic [3:0] pin4FunctionSelect,
   input  wire logic       autoCalibrationGo,
   input  wire logic       calibrationDoneClear,
   input  wire logic       slowOscCalibrationGo,
   input  wire logic       slowOscOverride,
   input  wire logic       slowOscOn,
   input  wire logic       txDone,
   input  wire logic       rxDone,
   input  wire logic       syncMatch,
   input  wire logic       rxAirBit,
   input  wire logic       hostTxBit,
   input  wire logic [7:0] rxFifoByte,
   output logic            rxFifoPop,
   output logic            txPtrReset,
   output logic            rxPtrReset,
   output logic [7:0]      txFifoData,
   output logic            txFifoValid,
   input  wire logic       txFifoReady,
   output logic            txBufReady,
   output logic [2:0]      modeState,
   output logic            regulatorOn,
   output logic            crystalOn,
   output logic            slowOscRun,
   output logic            synthOn,
   output logic            txOn,
   output logic            rxOn,
   output logic            autoCalBusy,
   output logic            calibrationDoneFlag,
   output logic            slowOscCalBusy,
   output logic            wakeIrq,
   output logic            pin4Out,
   output logic            txBit
);
   localparam int BUF_AW = $clog2(BUF_DEPTH);

   if (BUF_DEPTH < 2 || (1 << BUF_AW) != BUF_DEPTH ||
       VCO_CAL_CYCLES < 1 || SLOW_CAL_CYCLES >= (1 << CNT_W)) begin : g_chk
      $error("rtc_cmd_ctrl: unsupported parameter value");
   end

   // ==========================================================
   // Command decode
   function automatic rtc_kind_e decode(input logic [7:0] b);
      if (b[7:6] == CMD_REGW_TOP) return K_REGW;
      if (b[7:6] == CMD_REGR_TOP) return K_REGR;
      if (b[7:4] == CMD_SYNW_HI) return b[0] ? K_TXF : K_SYNW;
      if (b[7:4] == CMD_SYNR_HI) begin
         if (b[3:0] == CMD_ID_LO) return K_ID;
         return b[0] ? K_RXF : K_SYNR;
      end
      if (b[7:5] == CMD_BANK_TOP) return K_BANK;
      if (b == CMD_SWRST || b == CMD_TXPTR || b == CMD_RXPTR ||
          b == CMD_DEEP || b == CMD_IDLE || b == CMD_LIGHT ||
          b == CMD_STBY || b == CMD_TX || b == CMD_RX) return K_STRB;
      return K_DROP;
   endfunction

   function automatic logic isRead(input rtc_kind_e k);
      return k == K_REGR || k == K_SYNR || k == K_RXF || k == K_ID;
   endfunction

   // ==========================================================
   // Link synchronisers
   logic selS1_q, selS2_q, lckS1_q, lckS2_q, lckS3_q;
   logic dinS1_q, dinS2_q, hbS1_q, hbS2_q;

   // Three flops on the link clock so edges are seen on settled levels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {selS1_q, selS2_q} <= 2'h3;
         {lckS1_q, lckS2_q, lckS3_q} <= 3'h0;
         {dinS1_q, dinS2_q, hbS1_q, hbS2_q} <= 4'h0;
      end else begin
         selS1_q <= linkSelect_n;
         selS2_q <= selS1_q;
         lckS1_q <= linkClk;
         lckS2_q <= lckS1_q;
         lckS3_q <= lckS2_q;
         dinS1_q <= linkDataIn;
         dinS2_q <= dinS1_q;
         hbS1_q  <= hostTxBit;
         hbS2_q  <= hbS1_q;
      end
   end

   // ==========================================================
   // Serial engine
   rtc_mode_e  state_q;
   rtc_kind_e  kind_q, cmdKind, rdKind;
   logic [2:0] bitCnt_q;
   logic [6:0] shIn_q;
   logic [7:0] shOut_q, newByte, rdByte;
   logic [5:0] addr_q, rdAddr;
   logic       dataPhase_q, active, rise, fall, byteDone;
   logic       cmdDone, dataDone, swReset, regWr, syncWr, txfWr;
   logic [7:0] regMem [64];
   logic [7:0] syncMem [8];

   assign active   = !selS2_q;
   assign rise     = lckS2_q && !lckS3_q;
   assign fall     = !lckS2_q && lckS3_q;
   assign newByte  = {shIn_q, dinS2_q};
   assign byteDone = active && rise && bitCnt_q == 3'h7;
   assign cmdDone  = byteDone && !dataPhase_q;
   assign dataDone = byteDone && dataPhase_q;
   assign cmdKind  = decode(newByte);
   assign swReset  = cmdDone && newByte == CMD_SWRST;
   // Power down keeps nothing, so register writes are refused there
   assign regWr  = dataDone && kind_q == K_REGW && state_q != M_PWRDN;
   assign syncWr = dataDone && kind_q == K_SYNW;
   assign txfWr  = dataDone && kind_q == K_TXF;
   assign rdKind = dataPhase_q ? kind_q : cmdKind;
   assign rdAddr = dataPhase_q ? 6'(addr_q + 6'h01) : newByte[5:0];

   // Next byte to send; address wraps through the 6-bit adder
   always_comb begin
      unique case (rdKind)
         K_REGR:  rdByte = regMem[rdAddr];
         K_SYNR:  rdByte = syncMem[rdAddr[2:0]];
         K_RXF:   rdByte = rxFifoByte;
         K_ID:    rdByte = ID_CODE;
         default: rdByte = 8'h00;
      endcase
   end

   // Shift in on rising edges, shift out on falling edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bitCnt_q <= 3'h0;
         shIn_q <= 7'h00;
         shOut_q <= 8'h00;
         addr_q <= 6'h00;
         dataPhase_q <= 1'b0;
         kind_q <= K_NONE;
         linkDataOut <= 1'b0;
         linkDataOe <= 1'b0;
         rxFifoPop <= 1'b0;
      end else begin
         rxFifoPop <= 1'b0;
         linkDataOe <= active && dataPhase_q && isRead(kind_q);
         if (!active) begin
            bitCnt_q <= 3'h0;
            dataPhase_q <= 1'b0;
            kind_q <= K_NONE;
         end else begin
            if (rise) begin
               bitCnt_q <= 3'(bitCnt_q + 3'h1);
               shIn_q <= newByte[6:0];
            end
            if (cmdDone) begin
               dataPhase_q <= 1'b1;
               kind_q <= cmdKind;
               addr_q <= newByte[5:0];
            end else if (dataDone) begin
               addr_q <= 6'(addr_q + 6'h01);
            end
            if (byteDone && isRead(rdKind)) begin
               shOut_q <= rdByte;
               rxFifoPop <= rdKind == K_RXF;
            end else if (fall && dataPhase_q && isRead(kind_q)) begin
               linkDataOut <= shOut_q[7];
               shOut_q <= {shOut_q[6:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // Register and sync-word storage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 64; i++) regMem[i] <= REG_RST;
         for (int i = 0; i < 8; i++) syncMem[i] <= REG_RST;
         bankSel <= 2'h0;
      end else if (swReset || state_q == M_PWRDN) begin
         for (int i = 0; i < 64; i++) regMem[i] <= REG_RST;
         for (int i = 0; i < 8; i++) syncMem[i] <= REG_RST;
         bankSel <= 2'h0;
      end else begin
         if (regWr) regMem[addr_q] <= newByte;
         if (syncWr) syncMem[addr_q[2:0]] <= newByte;
         if (cmdDone && cmdKind == K_BANK) bankSel <= newByte[1:0];
      end
   end

   // ==========================================================
   // Strobes to the FIFO pointers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txPtrReset <= 1'b0;
         rxPtrReset <= 1'b0;
      end else begin
         txPtrReset <= cmdDone && newByte == CMD_TXPTR;
         rxPtrReset <= cmdDone && newByte == CMD_RXPTR;
      end
   end

   // ==========================================================
   // Two-entry buffer on the TX FIFO write path
   logic [7:0]      bufMem [BUF_DEPTH];
   logic [BUF_AW-1:0] wp_q, rp_q;
   logic [BUF_AW:0]   cnt_q;
   logic            push, pop;

   assign txBufReady  = cnt_q != (BUF_AW+1)'(BUF_DEPTH);
   assign txFifoValid = cnt_q != '0;
   assign txFifoData  = bufMem[rp_q];
   assign push = txfWr && txBufReady;
   assign pop  = txFifoValid && txFifoReady;

   // A byte written while full is lost; txBufReady tells the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         for (int i = 0; i < BUF_DEPTH; i++) bufMem[i] <= 8'h00;
      end else if (swReset || txPtrReset) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            bufMem[wp_q] <= newByte;
            wp_q <= BUF_AW'(wp_q + 1'b1);
         end
         if (pop) rp_q <= BUF_AW'(rp_q + 1'b1);
         cnt_q <= (BUF_AW+1)'(cnt_q + push - pop);
      end
   end

   // ==========================================================
   // Operating mode sequencer
   rtc_mode_e        goal_q;
   logic [CNT_W-1:0] mcnt_q;
   logic             modeStb;

   assign modeStb = cmdDone && cmdKind == K_STRB &&
                    newByte != CMD_SWRST && newByte != CMD_TXPTR &&
                    newByte != CMD_RXPTR;
   assign modeState = state_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= M_PWRDN;
         goal_q <= M_STBY;
         mcnt_q <= '0;
      end else begin
         if (mcnt_q != '1) mcnt_q <= mcnt_q + 1'b1;
         unique case (state_q)
            M_PWRDN: if (mcnt_q >= CNT_W'(POR_CYC - 1)) begin
               state_q <= M_DEEP;
               mcnt_q <= '0;
            end
            M_WARM: if (mcnt_q >= CNT_W'(XTAL_UP_CYC - 1)) begin
               state_q <= M_LIGHT;
            end
            M_STBY: if (mcnt_q >= CNT_W'(SETTLE_CYC - 1)) begin
               if (dirModeEn && operatingMode[OPM_START])
                  state_q <= operatingMode[OPM_DIR] ? M_TX : M_RX;
               else if (!dirModeEn && goal_q != M_STBY)
                  state_q <= goal_q;
            end
            M_TX: if (!dirModeEn && txDone) state_q <= M_LIGHT;
            M_RX: if (!dirModeEn && rxDone) state_q <= M_LIGHT;
            M_DEEP, M_LIGHT, M_IDLE: ;
         endcase
         if (state_q != M_PWRDN && modeStb) begin
            mcnt_q <= '0;
            goal_q <= M_STBY;
            unique case (newByte)
               CMD_DEEP:  state_q <= M_DEEP;
               CMD_IDLE:  state_q <= M_IDLE;
               CMD_LIGHT: state_q <= M_WARM;
               CMD_STBY:  state_q <= M_STBY;
               CMD_TX: begin
                  state_q <= M_STBY;
                  goal_q <= M_TX;
               end
               default: begin
                  state_q <= M_STBY;
                  goal_q <= M_RX;
               end
            endcase
         end else if (dirModeEn && (state_q == M_LIGHT ||
                      state_q == M_STBY || state_q == M_TX ||
                      state_q == M_RX)) begin
            if (operatingMode == 3'h0 && state_q != M_LIGHT)
               state_q <= M_LIGHT;
            else if (operatingMode[OPM_SYNTH] && state_q == M_LIGHT) begin
               state_q <= M_STBY;
               mcnt_q <= '0;
            end
         end
      end
   end

   // Supply and block enables follow the mode one cycle later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {regulatorOn, crystalOn, slowOscRun} <= 3'h0;
         {synthOn, txOn, rxOn} <= 3'h0;
      end else begin
         regulatorOn <= state_q inside {M_WARM, M_LIGHT, M_STBY, M_TX, M_RX};
         crystalOn <= state_q inside {M_WARM, M_LIGHT, M_STBY, M_TX, M_RX};
         slowOscRun <= state_q == M_IDLE;
         synthOn <= state_q inside {M_STBY, M_TX, M_RX};
         txOn <= state_q == M_TX;
         rxOn <= state_q == M_RX;
      end
   end

   // ==========================================================
   // Calibration
   logic [CNT_W-1:0] calCnt_q, slowCnt_q;

   // Done set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         autoCalBusy <= 1'b0;
         calibrationDoneFlag <= 1'b0;
         calCnt_q <= '0;
      end else begin
         if (calibrationDoneClear) calibrationDoneFlag <= 1'b0;
         if (autoCalBusy) begin
            calCnt_q <= calCnt_q + 1'b1;
            if (calCnt_q == CNT_W'(VCO_CAL_CYCLES - 1)) begin
               autoCalBusy <= 1'b0;
               calibrationDoneFlag <= 1'b1;
            end
         end else if (autoCalibrationGo) begin
            autoCalBusy <= 1'b1;
            calCnt_q <= '0;
         end
      end
   end

   // Slow oscillator calibration only starts from light sleep
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         slowOscCalBusy <= 1'b0;
         slowCnt_q <= '0;
      end else if (slowOscCalBusy) begin
         slowCnt_q <= slowCnt_q + 1'b1;
         if (slowCnt_q == CNT_W'(SLOW_CAL_CYCLES - 1))
            slowOscCalBusy <= 1'b0;
      end else if (slowOscCalibrationGo && state_q == M_LIGHT &&
                   !slowOscOverride && slowOscOn) begin
         slowOscCalBusy <= 1'b1;
         slowCnt_q <= '0;
      end
   end

   // ==========================================================
   // Wake-up timer
   logic [CNT_W-1:0] wakeCnt_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeCnt_q <= '0;
         wakeIrq <= 1'b0;
      end else if (state_q != M_IDLE || !autoTxRxEnable) begin
         wakeCnt_q <= '0;
         wakeIrq <= wakeIrq && state_q == M_IDLE;
      end else if (wakeCnt_q == CNT_W'(WAKE_CYC - 1)) begin
         wakeIrq <= 1'b1;
      end else begin
         wakeCnt_q <= wakeCnt_q + 1'b1;
      end
   end

   // ==========================================================
   // Direct-mode bit clock and data
   logic [CNT_W-1:0] halfCnt_q;
   logic             bitClk_q, dirRun, halfEnd, bitFall;

   assign dirRun  = dirModeEn &&
                    (state_q == M_TX || (state_q == M_RX && syncMatch));
   assign halfEnd = halfCnt_q == CNT_W'(BIT_HALF_CYC - 1);
   assign bitFall = dirRun && halfEnd && bitClk_q;

   // Equal high and low halves give the 50% duty cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         halfCnt_q <= '0;
         bitClk_q <= 1'b0;
      end else if (!dirRun) begin
         halfCnt_q <= '0;
         bitClk_q <= 1'b0;
      end else if (halfEnd) begin
         halfCnt_q <= '0;
         bitClk_q <= !bitClk_q;
      end else begin
         halfCnt_q <= halfCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txBit <= 1'b0;
         pin4Out <= 1'b0;
      end else begin
         // Predicts the next clock level, so it also drops with dirRun
         pin4Out <= pin4FunctionSelect == PIN4_BITCLK &&
                    dirRun && (bitClk_q ^ halfEnd);
         if (bitFall && state_q == M_TX) txBit <= hbS2_q;
         else if (bitFall) txBit <= rxAirBit;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_por_to_deep: assert property (state_q == M_PWRDN &&
      mcnt_q == CNT_W'(POR_CYC - 1) |=> state_q == M_DEEP)
      else $error("power-on did not reach deep sleep");
   a_light_via_warm: assert property (cmdDone && newByte == CMD_LIGHT &&
      state_q == M_DEEP |=> state_q == M_WARM)
      else $error("light sleep skipped crystal start");
   a_settle_first: assert property ($rose(state_q == M_TX) |->
      $past(state_q) == M_STBY)
      else $error("TX entered without standby");
   a_fifo_return: assert property (state_q == M_RX && rxDone &&
      !dirModeEn && !modeStb |=> state_q == M_LIGHT)
      else $error("RX done did not return to light sleep");
   a_idle_power: assert property (state_q == M_IDLE [*2] |->
      slowOscRun && !regulatorOn && !crystalOn)
      else $error("idle supplies wrong");
   a_wake_gate: assert property (!autoTxRxEnable |=>
      wakeCnt_q == '0)
      else $error("wake timer ran while disabled");
   a_cal_done: assert property ($fell(autoCalBusy) |->
      calibrationDoneFlag)
      else $error("calibration end without flag");
   a_slow_gate: assert property ($rose(slowOscCalBusy) |->
      $past(state_q) == M_LIGHT && !$past(slowOscOverride))
      else $error("slow calibration started illegally");
   a_addr_incr: assert property (dataDone |=>
      addr_q == 6'($past(addr_q) + 6'h01))
      else $error("address did not advance");
   a_drop_quiet: assert property (kind_q == K_DROP |=>
      !linkDataOe)
      else $error("unknown command drove the link");
   a_tx_sample: assert property (bitFall && state_q == M_TX |=>
      txBit == $past(hbS2_q))
      else $error("TX bit not taken on clock fall");
endmodule

// >>> pkg/rtc_pkg.sv
package rtc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ      = 250;
   localparam int CLK_KHZ      = CLK_MHZ * 1000;
   localparam int SLOW_CAL_MS  = 4;
   localparam int SLOW_CAL_CYC = SLOW_CAL_MS * CLK_KHZ;
   localparam int VCO_CAL_US   = 152;
   localparam int VCO_CAL_CYC  = VCO_CAL_US * CLK_MHZ;
   localparam int POR_CYC      = 16;
   localparam int XTAL_UP_CYC  = 64;
   localparam int SETTLE_CYC   = 128;
   localparam int BIT_HALF_CYC = 8;
   localparam int WAKE_CYC     = 1024;
   localparam int CNT_W        = 20;

   // ==========================================================
   // Command encodings
   localparam logic [1:0] CMD_REGW_TOP = 2'h1;
   localparam logic [1:0] CMD_REGR_TOP = 2'h3;
   localparam logic [2:0] CMD_BANK_TOP = 3'h1;
   localparam logic [3:0] CMD_SYNW_HI  = 4'h1;
   localparam logic [3:0] CMD_SYNR_HI  = 4'h9;
   localparam logic [3:0] CMD_ID_LO    = 4'hF;
   localparam logic [7:0] CMD_SWRST    = 8'h08;
   localparam logic [7:0] CMD_TXPTR    = 8'h09;
   localparam logic [7:0] CMD_RXPTR    = 8'h89;
   localparam logic [7:0] CMD_DEEP     = 8'h0A;
   localparam logic [7:0] CMD_IDLE     = 8'h0B;
   localparam logic [7:0] CMD_LIGHT    = 8'h0C;
   localparam logic [7:0] CMD_STBY     = 8'h0D;
   localparam logic [7:0] CMD_TX       = 8'h0E;
   localparam logic [7:0] CMD_RX       = 8'h8E;

   // ==========================================================
   // Fields and reset values
   localparam logic [3:0] PIN4_BITCLK  = 4'h5;
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam int         OPM_SYNTH    = 0;
   localparam int         OPM_DIR      = 1;
   localparam int         OPM_START    = 2;

   typedef enum logic [2:0] {
      M_PWRDN = 3'h0, M_DEEP = 3'h1, M_LIGHT = 3'h2, M_IDLE = 3'h3,
      M_STBY  = 3'h4, M_TX   = 3'h5, M_RX    = 3'h6, M_WARM = 3'h7
   } rtc_mode_e;

   typedef enum logic [3:0] {
      K_NONE = 4'h0, K_REGW = 4'h1, K_REGR = 4'h2, K_SYNW = 4'h3,
      K_SYNR = 4'h4, K_TXF  = 4'h5, K_RXF  = 4'h6, K_ID   = 4'h7,
      K_BANK = 4'h8, K_STRB = 4'h9, K_DROP = 4'hA
   } rtc_kind_e;
endpackage

// >>> verification/rtc_host_model.sv
`timescale 1ns/1ns
// ==========
// Host end of the serial link, master of select and clock
module rtc_host_model (
   output logic     linkSelect_n,
   output logic     linkClk,
   output logic     linkDataIn,
   input wire logic linkDataOut
);
   // Link clock rests low outside frames
   initial begin
      linkSelect_n = 1'b1;
      linkClk = 1'b0;
      linkDataIn = 1'b0;
   end
   // Select low for the whole access, with margin for its sync
   task sel();
      #40 linkSelect_n = 1'b0;
      #40;
   endtask
   // Released data shows the inverse so no stale value passes
   task desel();
      #40 linkSelect_n = 1'b1;
      linkDataIn = ~linkDataIn;
      #80;
   endtask
   // MSB first: data set before the rise, read data taken at it
   task xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         linkDataIn = d[i];
         #40 linkClk = 1'b1;
         q[i] = linkDataOut;
         #40 linkClk = 1'b0;
      end
   endtask
endmodule

// >>> verification/rtc_cmd_ctrl_tb.sv
`timescale 1ns/1ns
module rtc_cmd_ctrl_tb import rtc_pkg::*;;
   logic clk, reset_n, linkSelect_n, linkClk, linkDataIn, linkDataOut;
   logic linkDataOe, dirModeEn, autoTxRxEnable, autoCalibrationGo;
   logic calibrationDoneClear, slowOscCalibrationGo, slowOscOverride;
   logic slowOscOn, txDone, rxDone, syncMatch, rxAirBit, hostTxBit;
   logic rxFifoPop, txPtrReset, rxPtrReset, txFifoValid, txFifoReady;
   logic txBufReady, regulatorOn, crystalOn, slowOscRun, synthOn, txOn;
   logic rxOn, autoCalBusy, calibrationDoneFlag, slowOscCalBusy, wakeIrq;
   logic pin4Out, txBit;
   logic [1:0] bankSel;
   logic [2:0] operatingMode, modeState;
   logic [3:0] pin4FunctionSelect;
   logic [7:0] rxFifoByte, txFifoData, q;
   int         error_cnt, checks, pulses, hi;
   // Short calibrations keep the run brief; ID value is arbitrary
   rtc_cmd_ctrl #(.SLOW_CAL_CYCLES(50), .VCO_CAL_CYCLES(20),
      .ID_CODE(8'hC3)) u_dut (.*);
   rtc_host_model u_host (.*);
   // ==========
   // Clock, pulse counter and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Counts one-cycle pulses so that a stuck pulse shows up
   always @(posedge clk) pulses <= pulses + txPtrReset + rxPtrReset;
   // Watchdog at several times the expected run
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
   // ==========
   // Shared tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task test_done();
      $display("checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait, then two cycles for the enables to follow
   task wm(input logic [2:0] m);
      for (int i = 0; i < 2000 && modeState !== m; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1 chk(8'(modeState), 8'(m));
   endtask
   task st(input logic [7:0] c);
      u_host.sel();
      u_host.xfer(c, q);
      u_host.desel();
   endtask
   // Two bytes written in one frame, read back in another
   task wr2(input logic [7:0] w, r, a, b);
      st(w);
      u_host.sel();
      u_host.xfer(w, q);
      u_host.xfer(a, q);
      u_host.xfer(b, q);
      u_host.desel();
      u_host.sel();
      u_host.xfer(r, q);
      u_host.xfer(8'h00, q);
      chk(q, a);
      u_host.xfer(8'h00, q);
      chk(q, b);
      u_host.desel();
   endtask
   // ==========
   // Main sequence
   initial begin
      {reset_n, dirModeEn, autoTxRxEnable, autoCalibrationGo} = '0;
      {calibrationDoneClear, slowOscCalibrationGo, slowOscOverride} = '0;
      {slowOscOn, txDone, rxDone, syncMatch, rxAirBit, hostTxBit} = '0;
      {operatingMode, pin4FunctionSelect, txFifoReady} = '0;
      rxFifoByte = 8'h3C;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      #1 chk(8'(modeState), 8'(M_PWRDN));
      wm(M_DEEP);
      st(CMD_LIGHT);
      wm(M_LIGHT);
      chk(8'({regulatorOn, crystalOn, slowOscRun}), 8'h06);
      wr2(8'h7F, 8'hFF, 8'hA5, 8'h5A);
      wr2(8'h1E, 8'h9E, 8'hC6, 8'h39);
      u_host.sel();
      u_host.xfer(8'h9F, q);
      u_host.xfer(8'h00, q);
      chk(q, 8'hC3);
      chk(8'(linkDataOe), 8'h01);
      u_host.desel();
      chk(8'(linkDataOe), 8'h00);
      u_host.sel();
      u_host.xfer(8'h91, q);
      u_host.xfer(8'h00, q);
      chk(q, 8'h3C);
      u_host.desel();
      hi = pulses;
      st(CMD_TXPTR);
      st(CMD_RXPTR);
      chk(8'(pulses - hi), 8'h02);
      st(8'h3D);
      chk(8'(bankSel), 8'h01);
      st(CMD_SWRST);
      chk(8'(bankSel), 8'h00);
      wr2(8'h40, 8'hC0, 8'h81, 8'h18);
      // Stalled consumer: third byte finds the buffer full
      u_host.sel();
      u_host.xfer(8'h11, q);
      for (int i = 1; i < 4; i++) u_host.xfer({4'hB, 4'(i)}, q);
      u_host.desel();
      chk(8'({txBufReady, txFifoValid}), 8'h01);
      chk(txFifoData, 8'hB1);
      @(posedge clk) txFifoReady <= 1'b1;
      @(posedge clk);
      #1 chk(txFifoData, 8'hB2);
      @(posedge clk) txFifoReady <= 1'b0;
      #1 chk(8'(txFifoValid), 8'h00);
      @(posedge clk) autoCalibrationGo <= 1'b1;
      @(posedge clk) autoCalibrationGo <= 1'b0;
      #1;
      for (int i = 0; i < 300 && autoCalBusy !== 1'b0; i++) @(posedge clk);
      #1 chk(8'({autoCalBusy, calibrationDoneFlag}), 8'h01);
      @(posedge clk) calibrationDoneClear <= 1'b1;
      @(posedge clk) calibrationDoneClear <= 1'b0;
      #1 chk(8'(calibrationDoneFlag), 8'h00);
      @(posedge clk) slowOscOn <= 1'b1;
      slowOscCalibrationGo <= 1'b1;
      @(posedge clk) slowOscCalibrationGo <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(8'(slowOscCalBusy), 8'h01);
      repeat (80) @(posedge clk);
      #1 chk(8'(slowOscCalBusy), 8'h00);
      // Strobed TX then RX, each ended by its done pulse
      for (int k = 0; k < 2; k++) begin
         st(k ? CMD_RX : CMD_TX);
         #1 chk(8'(modeState), 8'(M_STBY));
         wm(k ? M_RX : M_TX);
         chk(8'({synthOn, txOn, rxOn}), k ? 8'h05 : 8'h06);
         @(posedge clk) {txDone, rxDone} <= k ? 2'b01 : 2'b10;
         @(posedge clk) {txDone, rxDone} <= 2'b00;
         wm(M_LIGHT);
      end
      st(CMD_STBY);
      wm(M_STBY);
      st(CMD_IDLE);
      wm(M_IDLE);
      chk(8'({regulatorOn, crystalOn, slowOscRun}), 8'h01);
      repeat (WAKE_CYC + 50) @(posedge clk);
      #1 chk(8'(wakeIrq), 8'h00);
      @(posedge clk) autoTxRxEnable <= 1'b1;
      for (int i = 0; i < 1500 && wakeIrq !== 1'b1; i++) @(posedge clk);
      #1 chk(8'(wakeIrq), 8'h01);
      @(posedge clk) autoTxRxEnable <= 1'b0;
      st(CMD_LIGHT);
      wm(M_LIGHT);
      // Direct mode, host bit held steady across bit clock falls
      // Host and air bits differ, so each direction shows its source
      @(posedge clk) dirModeEn <= 1'b1;
      pin4FunctionSelect <= PIN4_BITCLK;
      {hostTxBit, rxAirBit, syncMatch} <= 3'b101;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) operatingMode <= k ? 3'b001 : 3'b011;
         wm(M_STBY);
         @(posedge clk) operatingMode <= k ? 3'b101 : 3'b111;
         wm(k ? M_RX : M_TX);
         hi = 0;
         for (int i = 0; i < 160; i++) begin
            @(posedge clk);
            hi += pin4Out;
         end
         chk(8'(hi), 8'h50);
         chk(8'(txBit), k ? 8'h00 : 8'h01);
         @(posedge clk) operatingMode <= 3'b000;
         wm(M_LIGHT);
      end
      st(CMD_DEEP);
      wm(M_DEEP);
      u_host.sel();
      u_host.xfer(8'h80, q);
      u_host.xfer(8'h3E, q);
      u_host.desel();
      chk(8'(bankSel), 8'h00);
      test_done();
   end
endmodule
